// ---- verilog/usp_sync_port.sv ----
// Summary of operation
// - Drive data bus only while drive-enable low
// - Receive-available low only when byte readable
// - Byte out each clock both low
// - Transmit-space low only when byte accepted
// - Byte in each clock both low
// - Read shows current byte, then advances
// - Write stores one byte per clock
// - Device drives interface clock; all synchronous
// - Wakeup strobe in suspend requests resume
// - Strobe in normal use flushes transmit buffer
// - Bus and handshakes sampled on rising edge, updated on falling
// - Mode active only when configured and commanded
`timescale 1ns/1ps
`include "usp_params.svh"

module usp_sync_port
  import usp_pkg::*;
#(
  parameter int DATA_W     = `USP_DATA_W,
  parameter int FIFO_DEPTH = `USP_FIFO_DEPTH,
  parameter int IFCLK_HALF = `USP_IFCLK_HALF
) (
  input  wire logic              clock_i,                // System clock
  input  wire logic              nrst_i,                 // Sync reset, low
  // Pin side
  input  wire logic [DATA_W-1:0] fifo_data_bus_i,        // Bus level seen
  output logic      [DATA_W-1:0] fifo_data_bus_o,        // Bus drive value
  output logic                   fifo_data_bus_oe_o,     // High while driving
  output logic                   rx_data_available_n_o,  // Byte readable, low
  output logic                   tx_space_available_n_o, // Space free, low
  output logic                   interface_clock_out_o,  // Interface clock
  input  wire logic              read_strobe_n_i,        // Read strobe, low
  input  wire logic              write_strobe_n_i,       // Write strobe, low
  input  wire logic              bus_drive_en_n_i,       // Drive enable, low
  input  wire logic              send_now_wakeup_n_i,    // Flush/wake, low
  output logic                   usb_active_n_o,         // Low when not suspended
  // USB-engine side
  input  wire logic [DATA_W-1:0] usb_rx_data_i,          // Byte from host
  input  wire logic              usb_rx_valid_i,         // Byte offered
  output logic                   usb_rx_ready_o,         // Receive buffer space
  output logic      [DATA_W-1:0] usb_tx_data_o,          // Byte to host
  output logic                   usb_tx_valid_o,         // Byte waiting
  input  wire logic              usb_tx_ready_i,         // Engine takes byte
  input  wire logic              usb_suspended_i,        // Bus in suspend
  input  wire logic              remote_wakeup_en_i,     // Wakeup allowed
  input  wire logic              chan_fifo_cfg_i,        // Channel set to FIFO
  input  wire logic              sync_mode_cmd_i,        // Sync mode selected
  output logic                   resume_request_o,       // Resume pulse
  output logic                   send_now_o              // Flush pulse
);

  // ----------------------------------------------------------------
  // Interface clock divider
  // ----------------------------------------------------------------
  // Half period of at least 2 local cycles, so synced pins
  // settle between two link edges
  localparam int HW = $clog2(IFCLK_HALF + 1);

  logic [HW-1:0] div_cnt;
  wire logic     div_wrap = (div_cnt == HW'(IFCLK_HALF - 1));
  wire logic     if_rise  = div_wrap && !interface_clock_out_o;
  wire logic     if_fall  = div_wrap && interface_clock_out_o;

  // Device makes the link clock; rate is set by the divider
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      div_cnt               <= '0;
      interface_clock_out_o <= 1'b0;
    end else begin
      div_cnt <= div_wrap ? '0 : div_cnt + 1'b1;
      if (div_wrap) begin
        interface_clock_out_o <= !interface_clock_out_o;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Byte and strobes cross as one vector, so both
  // are seen on the same local edge
  localparam int SW = DATA_W + 4;

  logic [SW-1:0] pin_m;
  logic [SW-1:0] pin_s;
  logic          wake_prev;

  wire logic [DATA_W-1:0] bus_s  = pin_s[DATA_W-1:0];
  wire logic              rd_n_s = pin_s[DATA_W];
  wire logic              wr_n_s = pin_s[DATA_W+1];
  wire logic              oe_n_s = pin_s[DATA_W+2];
  wire logic              wk_n_s = pin_s[DATA_W+3];

  // Two stages; the first is read by the second only
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      pin_m <= {4'hF, DATA_W'(`USP_RST_BYTE)};
      pin_s <= {4'hF, DATA_W'(`USP_RST_BYTE)};
    end else begin
      pin_m <= {send_now_wakeup_n_i, bus_drive_en_n_i, write_strobe_n_i,
                read_strobe_n_i, fifo_data_bus_i};
      pin_s <= pin_m;
    end
  end

  // ----------------------------------------------------------------
  // Mode select
  // ----------------------------------------------------------------
  usp_mode_e mode;
  wire logic mode_on = (mode == USP_MODE_SYNC);

  // Needs both the channel setting and the command
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      mode <= USP_MODE_OFF;
    end else begin
      mode <= (chan_fifo_cfg_i && sync_mode_cmd_i) ? USP_MODE_SYNC
                                                   : USP_MODE_OFF;
    end
  end

  // ----------------------------------------------------------------
  // Buffers and transfer decode
  // ----------------------------------------------------------------
  wire logic              rx_valid;
  wire logic [DATA_W-1:0] rx_head;
  wire logic              tx_ready;
  wire logic              tx_out_valid;
  wire logic [DATA_W-1:0] tx_out_data;
  wire logic              rx_in_ready;

  // Transfers are taken on the rising link edge only
  wire logic rd_xfer = if_rise && mode_on && !rx_data_available_n_o
                       && !rd_n_s;
  wire logic wr_xfer = if_rise && mode_on && !tx_space_available_n_o
                       && !wr_n_s;

  // Engine-side outputs are wired from buffer state flops
  assign usb_rx_ready_o = rx_in_ready;
  assign usb_tx_valid_o = tx_out_valid;
  assign usb_tx_data_o  = tx_out_data;

  usp_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .clock_i     (clock_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (usb_rx_valid_i),
    .in_ready_o  (rx_in_ready),
    .in_data_i   (usb_rx_data_i),
    .out_valid_o (rx_valid),
    .out_ready_i (rd_xfer),
    .out_data_o  (rx_head)
  );

  usp_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clock_i     (clock_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (wr_xfer),
    .in_ready_o  (tx_ready),
    .in_data_i   (bus_s),
    .out_valid_o (tx_out_valid),
    .out_ready_i (usb_tx_ready_i),
    .out_data_o  (tx_out_data)
  );

  // ----------------------------------------------------------------
  // Pin-side flags and read data
  // ----------------------------------------------------------------
  // Updated at the falling link edge, mid-period, so the far side
  // sees settled values at its next rising edge after any transfer
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      rx_data_available_n_o  <= `USP_RST_FLAG_N;
      tx_space_available_n_o <= `USP_RST_FLAG_N;
      fifo_data_bus_o        <= DATA_W'(`USP_RST_BYTE);
    end else if (if_fall) begin
      rx_data_available_n_o  <= !(mode_on && rx_valid);
      tx_space_available_n_o <= !(mode_on && tx_ready);
      fifo_data_bus_o        <= rx_head;
    end
  end

  // Bus stays an input unless drive-enable is held low
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      fifo_data_bus_oe_o <= 1'b0;
    end else begin
      fifo_data_bus_oe_o <= mode_on && !oe_n_s;
    end
  end

  // ----------------------------------------------------------------
  // Send-now / wakeup strobe
  // ----------------------------------------------------------------
  // Previous level resets high, the idle level, so no false edge
  wire logic wake_fall = wake_prev && !wk_n_s;

  // One strobe gives at most one pulse; suspend state picks its meaning
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      wake_prev        <= 1'b1;
      resume_request_o <= 1'b0;
      send_now_o       <= 1'b0;
      usb_active_n_o   <= 1'b1;
    end else begin
      wake_prev        <= wk_n_s;
      usb_active_n_o   <= usb_suspended_i;
      resume_request_o <= wake_fall && mode_on && usb_suspended_i
                          && remote_wakeup_en_i;
      send_now_o       <= wake_fall && mode_on && !usb_suspended_i;
    end
  end

endmodule

// ---- verilog/usp_params.svh ----
`ifndef USP_PARAMS_SVH
`define USP_PARAMS_SVH

// ----------------------------------------------------------------
// Widths and buffer depth
// ----------------------------------------------------------------
`define USP_DATA_W        8
`define USP_FIFO_DEPTH    8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
// Nominal interface clock, in MHz
`define USP_IFCLK_MHZ     60
// Local clock, in MHz
`define USP_SYS_CLK_MHZ   40
// Local cycles per half interface period, as built
`define USP_IFCLK_HALF    4

// ----------------------------------------------------------------
// Reset values of the pin side
// ----------------------------------------------------------------
`define USP_RST_FLAG_N    1'b1
`define USP_RST_BYTE      8'h00

`endif

// ---- verilog/usp_pkg.sv ----
package usp_pkg;

  // Port mode; Gray step from off to synchronous
  typedef enum logic [1:0] {
    USP_MODE_OFF  = 2'b00,
    USP_MODE_SYNC = 2'b01
  } usp_mode_e;

endpackage

// ---- verilog/usp_fifo.sv ----
`timescale 1ns/1ps
`include "usp_params.svh"

module usp_fifo #(
  parameter int WIDTH = `USP_DATA_W,
  parameter int DEPTH = `USP_FIFO_DEPTH
) (
  input  wire logic             clock_i,      // System clock
  input  wire logic             nrst_i,       // Sync reset, low
  input  wire logic             in_valid_i,   // Write request
  output wire logic             in_ready_o,   // Space free
  input  wire logic [WIDTH-1:0] in_data_i,    // Write data
  output wire logic             out_valid_o,  // Data held
  input  wire logic             out_ready_i,  // Read accept
  output wire logic [WIDTH-1:0] out_data_o    // Head word
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [CW-1:0]    count;

  wire logic do_push = in_valid_i && in_ready_o;
  wire logic do_pop  = out_valid_o && out_ready_i;

  // Flags come from the count alone, so full and empty never lie
  assign in_ready_o  = (count != CW'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];

  // Storage has no reset; only pointers and count need defined values
  always_ff @(posedge clock_i) begin
    if (do_push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // Pointers wrap at DEPTH, which need not be a power of two
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + CW'(do_push) - CW'(do_pop);
    end
  end

endmodule

// ---- sim/usp_sync_port_chk.sv ----
`timescale 1ns/1ps
module usp_sync_port_chk #(
  parameter int FIFO_DEPTH = 8,
  parameter int IFCLK_HALF = 4
) (
  input wire logic       clock_i,                // Clock
  input wire logic       nrst_i,                 // Reset, low
  input wire logic [7:0] fifo_data_bus_o,        // Bus value
  input wire logic       fifo_data_bus_oe_o,     // Bus drive
  input wire logic       rx_data_available_n_o,  // Rx flag
  input wire logic       tx_space_available_n_o, // Tx flag
  input wire logic       interface_clock_out_o,  // Link clock
  input wire logic       read_strobe_n_i,        // Read
  input wire logic       write_strobe_n_i,       // Write
  input wire logic       bus_drive_en_n_i,       // Drive enable
  input wire logic       send_now_wakeup_n_i,    // Flush/wake
  input wire logic       usb_rx_valid_i,         // Rx offer
  input wire logic       usb_rx_ready_o,         // Rx space
  input wire logic       usb_tx_valid_o,         // Tx offer
  input wire logic       usb_tx_ready_i,         // Tx take
  input wire logic       usb_suspended_i,        // Suspend
  input wire logic       remote_wakeup_en_i,     // Wake armed
  input wire logic       chan_fifo_cfg_i,        // Config
  input wire logic       sync_mode_cmd_i,        // Command
  input wire logic       resume_request_o,       // Resume
  input wire logic       send_now_o              // Flush
);
  // --------------------
  // Shadow state
  // --------------------
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  int         rxc, txc, hc;
  logic       ck_q, md;
  logic [2:0] rd_q, wr_q;
  wire        tog  = interface_clock_out_o ^ ck_q;
  wire        rise = interface_clock_out_o & ~ck_q;
  // Pin transfers seen an edge late, so rxc errs high and txc errs low
  always_ff @(posedge clock_i) begin
    ck_q <= interface_clock_out_o;
    rd_q <= {rd_q[1:0], read_strobe_n_i};
    wr_q <= {wr_q[1:0], write_strobe_n_i};
    hc   <= !nrst_i ? 0 : (tog ? 1 : hc + int'(hc != 0));
    md   <= nrst_i & (md | (chan_fifo_cfg_i & sync_mode_cmd_i));
    rxc  <= !nrst_i ? 0 : rxc + int'(usb_rx_valid_i & usb_rx_ready_o)
            - int'(rise & ~rx_data_available_n_o & ~rd_q[2]);
    txc  <= !nrst_i ? 0 : txc - int'(usb_tx_valid_o & usb_tx_ready_i)
            + int'(rise & ~tx_space_available_n_o & ~wr_q[2]);
  end
  sequence strobe_low;
    $fell(send_now_wakeup_n_i) ##1 !send_now_wakeup_n_i;
  endsequence
  chk_drive_enable: assert property (fifo_data_bus_oe_o |-> !$past(bus_drive_en_n_i, 3))
    else $error("bus driven without enable");
  chk_rx_nonempty: assert property ($fell(interface_clock_out_o)
    && !rx_data_available_n_o |-> rxc > 0)
    else $error("rx flag low while empty");
  chk_tx_space: assert property ($fell(interface_clock_out_o)
    && !tx_space_available_n_o |-> txc < FIFO_DEPTH)
    else $error("tx flag low while full");
  chk_link_period: assert property (tog && hc != 0 |-> hc == IFCLK_HALF)
    else $error("link clock half period wrong");
  chk_flag_hold: assert property ($changed(rx_data_available_n_o) || $changed(fifo_data_bus_o)
    || $changed(tx_space_available_n_o) |-> $fell(interface_clock_out_o))
    else $error("pin output moved off link edge");
  chk_mode_gate: assert property (!md |-> rx_data_available_n_o
    && tx_space_available_n_o && !fifo_data_bus_oe_o)
    else $error("pins active with mode off");
  chk_resume_req: assert property (strobe_low ##0 (md && usb_suspended_i
    && remote_wakeup_en_i) |-> ##[1:8] resume_request_o)
    else $error("no resume after strobe");
  chk_flush_req: assert property (strobe_low ##0 (md && !usb_suspended_i)
    |-> ##[1:8] send_now_o)
    else $error("no flush after strobe");
  chk_pulse_single: assert property (resume_request_o || send_now_o
    |=> !resume_request_o && !send_now_o)
    else $error("strobe pulse too long");
endmodule
bind usp_sync_port usp_sync_port_chk #(.FIFO_DEPTH(FIFO_DEPTH), .IFCLK_HALF(IFCLK_HALF)) chk (.*);

// ---- sim/usp_host_model.sv ----
`timescale 1ns/1ps
module usp_host_model (
  input  wire logic       clock_i,      // Local clock
  input  wire logic       nrst_i,       // Reset, low
  input  wire logic       link_clk_i,   // Link clock
  input  wire logic       rx_avail_n_i, // Rx flag
  input  wire logic       tx_space_n_i, // Tx flag
  input  wire logic [7:0] bus_i,        // Bus level
  input  wire logic       rd_en_i,      // Want reads
  input  wire logic       wr_en_i,      // Want writes
  output logic            rd_n_o,       // Read strobe
  output logic            wr_n_o,       // Write strobe
  output logic            oe_n_o,       // Drive enable
  output logic            drv_o,        // Host drives bus
  output logic            got_o,        // Byte read
  output logic            put_o,        // Byte written
  output logic      [7:0] byte_o        // Byte read value
);
  // --------------------
  // Link-side host
  // --------------------
  logic ck_q;
  wire  rise = link_clk_i & ~ck_q;
  // Acts one local edge after a link rise; pins settle well before the next
  always_ff @(posedge clock_i) begin
    ck_q   <= link_clk_i;
    got_o  <= rise & ~rd_n_o & ~rx_avail_n_i;
    put_o  <= rise & ~wr_n_o & ~tx_space_n_i;
    byte_o <= rise ? bus_i : byte_o;
    if (!nrst_i) begin
      {rd_n_o, wr_n_o, oe_n_o, drv_o} <= 4'hE;
    end else if (rise) begin
      drv_o  <= wr_en_i & ~rd_en_i & oe_n_o;
      oe_n_o <= ~rd_en_i | drv_o;
      rd_n_o <= ~rd_en_i | oe_n_o | rx_avail_n_i;
      wr_n_o <= ~wr_en_i | rd_en_i | ~drv_o | tx_space_n_i;
    end
  end
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  // --------------------
  // Bench state
  // --------------------
  logic       clock_i, nrst_i = 1'h0, rd_en = 1'h1, wr_en = 1'h1, send_now_wakeup_n = 1'h1;
  logic       feed = 1'h1, drain = 1'h0, rx_v = 1'h0, tx_r = 1'h0;
  logic       susp = 1'h0, wake = 1'h0, cfg = 1'h1, cmd = 1'h0;
  logic [7:0] rx_d = 8'h00, wbyte = 8'h5A, bo, txd, gbyte;
  logic       boe, rxf, txe, lck, rxr, txv, act, res, sn, rd_n, wr_n, oe_n, drv, got, put;
  logic [7:0] rq[$], tq[$];
  int         num_errors = 0, checks_done = 0, cyc = 0, n_res = 0, n_sn = 0;
  int         seed = 90491, r0, s0;
  wire  [7:0] bus = boe ? bo : (drv ? wbyte : ~wbyte); // Released bus shows inverse
  usp_sync_port #(.IFCLK_HALF(4)) dut (
    .clock_i(clock_i), .nrst_i(nrst_i), .fifo_data_bus_i(bus), .fifo_data_bus_o(bo),
    .fifo_data_bus_oe_o(boe), .rx_data_available_n_o(rxf), .tx_space_available_n_o(txe),
    .interface_clock_out_o(lck), .read_strobe_n_i(rd_n), .write_strobe_n_i(wr_n),
    .bus_drive_en_n_i(oe_n), .send_now_wakeup_n_i(send_now_wakeup_n), .usb_active_n_o(act),
    .usb_rx_data_i(rx_d), .usb_rx_valid_i(rx_v), .usb_rx_ready_o(rxr), .usb_tx_data_o(txd),
    .usb_tx_valid_o(txv), .usb_tx_ready_i(tx_r), .usb_suspended_i(susp),
    .remote_wakeup_en_i(wake), .chan_fifo_cfg_i(cfg), .sync_mode_cmd_i(cmd),
    .resume_request_o(res), .send_now_o(sn));
  usp_host_model host (
    .clock_i(clock_i), .nrst_i(nrst_i), .link_clk_i(lck), .rx_avail_n_i(rxf),
    .tx_space_n_i(txe), .bus_i(bus), .rd_en_i(rd_en), .wr_en_i(wr_en), .rd_n_o(rd_n),
    .wr_n_o(wr_n), .oe_n_o(oe_n), .drv_o(drv), .got_o(got), .put_o(put), .byte_o(gbyte));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    if (num_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic run(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // Suspended and armed asks for resume; awake flushes
  function automatic logic [1:0] pulse_exp(input logic s, input logic w);
    return {s & w, ~s};
  endfunction
  initial begin
    clock_i = 1'h0;
    forever #12.5 clock_i = ~clock_i;
  end
  // --------------------
  // Engine side and scoreboard
  // --------------------
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      conclude();
    end
    // Reset empties the receive buffer, so pushes then do not count
    if (rx_v && rxr && nrst_i) rq.push_back(rx_d);
    if (txv && tx_r) check(txd, tq.pop_front());
    if (got) check(gbyte, rq.pop_front());
    if (put) tq.push_back(wbyte);
    if (put) wbyte <= 8'($random(seed));
    n_res <= n_res + int'(res);
    n_sn <= n_sn + int'(sn);
    rx_v <= feed & 1'($random(seed));
    rx_d <= 8'($random(seed));
    // A pin write lands in the buffer before the host reports it
    tx_r <= drain & (tq.size() != 0) & 1'($random(seed));
  end
  // --------------------
  // Main sequence
  // --------------------
  initial begin
    run(3);
    nrst_i <= 1'h1;
    run(200);
    check(8'(rq.size()), 8'h08);
    check(8'({rxf, txe, boe, 5'(tq.size())}), 8'hC0);
    cmd <= 1'h1;
    feed <= 1'h0;
    run(400);
    check(8'({rxf, 7'(rq.size())}), 8'h80);
    rd_en <= 1'h0;
    run(400);
    check(8'({txe, 7'(tq.size())}), 8'h88);
    drain <= 1'h1;
    feed <= 1'h1;
    for (int i = 0; i < 12; i++) begin
      rd_en <= 1'($random(seed));
      wr_en <= 1'($random(seed));
      run(150);
    end
    feed <= 1'h0;
    rd_en <= 1'h1;
    run(400);
    check(8'(rq.size() + tq.size()), 8'h00);
    for (int c = 0; c < 4; c++) begin
      susp <= c[1];
      wake <= c[0];
      run(4);
      r0 = n_res;
      s0 = n_sn;
      send_now_wakeup_n <= 1'h0;
      run(8);
      send_now_wakeup_n <= 1'h1;
      run(16);
      check(8'(2 * (n_res - r0) + n_sn - s0), 8'(pulse_exp(c[1], c[0])));
      check(8'(act), 8'(c[1]));
    end
    nrst_i <= 1'h0;
    run(3);
    nrst_i <= 1'h1;
    run(1);
    check(8'({rxf, txe, boe, res, sn}), 8'h18);
    conclude();
  end
endmodule
